// >>> rtl/pin_mux_pkg.sv
`default_nettype none
package pin_mux_pkg;
  // Pin positions on the shared six-bit port
  localparam int NPINS = 6;
  localparam int PIN_CTRL_A = 0;
  localparam int PIN_CTRL_B = 1;
  localparam int PIN_FRAME_SYNC = 2;
  localparam int PIN_BIT_CLOCK = 3;
  localparam int PIN_RX_DATA = 4;
  localparam int PIN_TX_DATA = 5;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFF_DIRECTION = 8'h04;
  localparam logic [7:0] OFF_GP_OUT = 8'h08;
  localparam logic [7:0] OFF_GP_IN = 8'h0c;
  localparam logic [7:0] OFF_MODE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Field positions
  localparam int MODE_ASYNC_BIT = 0;
  localparam int STAT_STOP_BIT = 0;
  localparam int STAT_ASYNC_BIT = 1;

  // Values after reset
  localparam logic [5:0] FUNC_SEL_RST = 6'h00;
  localparam logic [5:0] DIRECTION_RST = 6'h00;
  localparam logic [5:0] GP_OUT_RST = 6'h00;
  localparam logic ASYNC_RST = 1'b0;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Drive from the serial port core toward the pins
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } ser_drv_s;

  // Pin roles as seen by the serial port core
  typedef struct packed {
    logic rx_bit_clk;
    logic rx_bit_clk_rise;
    logic rx_frame_sync;
    logic tx_frame_sync;
    logic tx_bit_clk;
    logic tx_bit_clk_rise;
    logic tx_bit_clk_fall;
    logic rx_data;
    logic flag0;
    logic flag1;
  } ser_in_s;
endpackage
`default_nettype wire

// >>> rtl/sync_serial_pin_mux.sv
// How it works
// - Async: pin A is receive bit clock
// - Sync: pin A is transmitter 1 or flag 0
// - Async: pin B is receive frame sync
// - Sync: pin B is transmitter 2 or flag 1
// - Frame sync pin shared sync, transmit-only async
// - Frame sync driven out or taken in
// - Bit clock pin clocks both, or transmitter
// - Receive data pin is input, feeds receiver
// - Transmit data pin driven by transmitter
// - Reset: all pins general-purpose inputs
// - Function select bit picks role per pin
// - Direction register steers general-purpose pins
// - Wait state leaves pins unchanged
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_pin_mux (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic stop_req,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pin_mux_pkg::ser_drv_s ser_drv,
  output pin_mux_pkg::ser_in_s ser_in,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe
);
  import pin_mux_pkg::*;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] held;
    logic [5:0] prev;
    logic [5:0] func_r;
    logic [5:0] dir_r;
    logic [5:0] gpo_r;
    logic async_r;
    logic [5:0] out_r;
    logic [5:0] oe_r;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [5:0] role;
  logic [5:0] role_prev;
  logic [5:0] sel_out;
  logic [5:0] sel_oe;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // Bus handshakes, frozen while the clock enable is low
  assign s_axi_awready = clk_en && !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = clk_en && !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = clk_en && !st_r.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFF_FUNC_SEL: rd_word[5:0] = st_r.func_r;
      OFF_DIRECTION: rd_word[5:0] = st_r.dir_r;
      OFF_GP_OUT: rd_word[5:0] = st_r.gpo_r;
      OFF_GP_IN: rd_word[5:0] = st_r.sync2;
      OFF_MODE: rd_word[MODE_ASYNC_BIT] = st_r.async_r;
      OFF_STATUS: begin
        rd_word[STAT_STOP_BIT] = stop_req;
        rd_word[STAT_ASYNC_BIT] = st_r.async_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Write target check
  always_comb begin
    case (st_r.awaddr)
      OFF_FUNC_SEL, OFF_DIRECTION, OFF_GP_OUT, OFF_MODE: wr_hit = 1'b1;
      OFF_GP_IN, OFF_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Per-pin function mux
  assign sel_out = (st_r.func_r & ser_drv.out) | (~st_r.func_r & st_r.gpo_r);
  always_comb begin
    sel_oe = (st_r.func_r & ser_drv.oe) | (~st_r.func_r & st_r.dir_r);
    if (st_r.func_r[PIN_RX_DATA]) begin
      sel_oe[PIN_RX_DATA] = 1'b0;
    end
  end

  // Serial-facing pin levels, only for pins given to the serial port
  assign role = st_r.held & st_r.func_r;
  assign role_prev = st_r.prev & st_r.func_r;

  // Role decode by operating mode
  always_comb begin
    ser_in = '0;
    ser_in.tx_frame_sync = role[PIN_FRAME_SYNC];
    ser_in.tx_bit_clk = role[PIN_BIT_CLOCK];
    ser_in.tx_bit_clk_rise = role[PIN_BIT_CLOCK] && !role_prev[PIN_BIT_CLOCK];
    ser_in.tx_bit_clk_fall = !role[PIN_BIT_CLOCK] && role_prev[PIN_BIT_CLOCK];
    ser_in.rx_data = role[PIN_RX_DATA];
    if (st_r.async_r) begin
      // Schmitt stage is the pad; the double flop removes metastability
      ser_in.rx_bit_clk = role[PIN_CTRL_A];
      ser_in.rx_bit_clk_rise = role[PIN_CTRL_A] && !role_prev[PIN_CTRL_A];
      ser_in.rx_frame_sync = role[PIN_CTRL_B];
    end else begin
      ser_in.rx_bit_clk = role[PIN_BIT_CLOCK];
      ser_in.rx_bit_clk_rise = ser_in.tx_bit_clk_rise;
      ser_in.rx_frame_sync = role[PIN_FRAME_SYNC];
      ser_in.flag0 = role[PIN_CTRL_A];
      ser_in.flag1 = role[PIN_CTRL_B];
    end
  end

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;
    if (clk_en) begin
      st_nxt.sync1 = pin_in;
      st_nxt.sync2 = st_r.sync1;
      if (!stop_req) begin
        st_nxt.held = st_r.sync2;
      end
      // Previous level tracks held, so no edge pulse stands through stop
      st_nxt.prev = st_r.held;
      // Wait state has no path into the pin drive
      st_nxt.out_r = sel_out;
      st_nxt.oe_r = stop_req ? 6'h00 : sel_oe;
      if (aw_hs) begin
        st_nxt.aw_got = 1'b1;
        st_nxt.awaddr = s_axi_awaddr;
      end
      if (w_hs) begin
        st_nxt.w_got = 1'b1;
        st_nxt.wdata = s_axi_wdata;
        st_nxt.wstrb0 = s_axi_wstrb[0];
      end
      if (st_r.aw_got && st_r.w_got) begin
        st_nxt.aw_got = 1'b0;
        st_nxt.w_got = 1'b0;
        st_nxt.bvalid = 1'b1;
        st_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (st_r.wstrb0) begin
          case (st_r.awaddr)
            OFF_FUNC_SEL: st_nxt.func_r = st_r.wdata[5:0];
            OFF_DIRECTION: st_nxt.dir_r = st_r.wdata[5:0];
            OFF_GP_OUT: st_nxt.gpo_r = st_r.wdata[5:0];
            OFF_MODE: st_nxt.async_r = st_r.wdata[MODE_ASYNC_BIT];
            default: st_nxt.gpo_r = st_r.gpo_r;
          endcase
        end
      end else if (st_r.bvalid && s_axi_bready) begin
        st_nxt.bvalid = 1'b0;
      end
      if (ar_hs) begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rdata = rd_word;
        st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (st_r.rvalid && s_axi_rready) begin
        st_nxt.rvalid = 1'b0;
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
      st_r.func_r <= FUNC_SEL_RST;
      st_r.dir_r <= DIRECTION_RST;
      st_r.gpo_r <= GP_OUT_RST;
      st_r.async_r <= ASYNC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin drive from flip-flops
  assign pin_out = st_r.out_r;
  assign pin_oe = st_r.oe_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // After reset every pin is a port input
  chk_reset_all_inputs: assert property (
    $past(rst) |-> (pin_oe == 6'h00) && (st_r.func_r == 6'h00))
    else $error("pins not port inputs after reset");

  // Port-mode pins follow the direction register
  chk_gp_direction: assert property (
    (clk_en && !stop_req && st_r.func_r == 6'h00)
    |=> pin_oe == $past(st_r.dir_r))
    else $error("port pin direction wrong");

  // Serial-mode pins carry the serial port drive
  chk_serial_select: assert property (
    (clk_en && st_r.func_r == 6'h3f)
    |=> pin_out == $past(ser_drv.out))
    else $error("serial drive not on pins");

  // Receive data pin never driven in serial mode
  chk_rx_pin_input: assert property (
    (clk_en && st_r.func_r[PIN_RX_DATA]) |=> !pin_oe[PIN_RX_DATA])
    else $error("receive data pin driven");

  // Transmit data pin enabled by the transmitter
  chk_tx_pin_drive: assert property (
    (clk_en && !stop_req && st_r.func_r[PIN_TX_DATA])
    |=> pin_oe[PIN_TX_DATA] == $past(ser_drv.oe[PIN_TX_DATA]))
    else $error("transmit data enable wrong");

  // Stop releases every pin
  chk_stop_release: assert property (
    (clk_en && stop_req) |=> pin_oe == 6'h00)
    else $error("pin driven in stop");

  // Serial inputs frozen across stop
  chk_stop_frozen: assert property (
    (stop_req ##1 stop_req) |-> $stable(st_r.held))
    else $error("serial input moved in stop");

  // Sync mode shares bit clock and frame sync
  chk_sync_shared: assert property (
    (!st_r.async_r) |-> (ser_in.rx_bit_clk == ser_in.tx_bit_clk)
    && (ser_in.rx_frame_sync == ser_in.tx_frame_sync))
    else $error("sync mode roles not shared");

  // Async mode takes receive clock and sync from control pins
  chk_async_roles: assert property (
    (st_r.async_r && st_r.func_r[1:0] == 2'b11)
    |-> (ser_in.rx_bit_clk == st_r.held[PIN_CTRL_A])
    && (ser_in.rx_frame_sync == st_r.held[PIN_CTRL_B])
    && !ser_in.flag0 && !ser_in.flag1)
    else $error("async roles wrong");

  // A pin level reaches the serial side in three cycles
  chk_pin_latency: assert property (
    (clk_en && !stop_req)[*4] |-> st_r.held == $past(pin_in, 3))
    else $error("pin latency wrong");

  // Write answered within three cycles of both halves
  chk_write_answer: assert property (
    (aw_hs && w_hs) |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");

  // Edge pulses last one enabled cycle
  chk_edge_pulse: assert property (
    (clk_en && ser_in.tx_bit_clk_rise) |=> !ser_in.tx_bit_clk_rise)
    else $error("bit clock edge pulse too long");

  // Clock enable low freezes all state
  chk_enable_freeze: assert property (
    !clk_en |=> $stable(st_r))
    else $error("state moved with clock enable low");

  cov_serial_all: cover property (clk_en && st_r.func_r == 6'h3f);
  cov_async_clk: cover property (st_r.async_r && ser_in.rx_bit_clk_rise);
  cov_sync_clk: cover property (!st_r.async_r && ser_in.tx_bit_clk_fall);
  cov_stop_entry: cover property (!stop_req ##1 stop_req);
endmodule
`default_nettype wire

// >>> sim/codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module codec_model (
  input wire logic frame_on,
  input wire logic [1:0] ctl_lvl,
  output logic [5:0] ext
);
  logic bclk, fsync, dat;
  // Still clock and levels until a frame starts
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    dat = 1'b0;
  end
  // Eight bits a frame, 125 ns bit period
  always @(posedge frame_on) begin
    #2; // Keep link edges off the system clock edges
    for (int i = 0; i < 8; i++) begin
      fsync = (i == 0);
      dat = i[0];
      #62.5 bclk = 1'b1;
      #62.5 bclk = 1'b0;
    end
    fsync = 1'b0;
  end
  // Undriven transmit line shows a changing pattern
  assign ext = {~dat, dat, bclk, fsync, ctl_lvl};
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pin_mux_pkg::*;
  logic clk_sys, rst, stop_req, frame_on, ce, prev_rd;
  logic [3:0] strb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, ctl_lvl, bsp, rsp;
  logic [5:0] pin_in, pin_out, pin_oe, ext;
  ser_drv_s drv;
  ser_in_s sin;
  int err_total, samples_checked, n, ntx, nrx, nfs, nrd, nfl;
  // Row: select, direction, port data, core out, core enable, oe, out
  logic [41:0] rows [4] = '{
    {6'h00, 6'h3f, 6'h0a, 6'h28, 6'h00, 6'h3f, 6'h0a},
    {6'h3f, 6'h00, 6'h03, 6'h15, 6'h3f, 6'h2f, 6'h15},
    {6'h15, 6'h2a, 6'h3c, 6'h33, 6'h1f, 6'h2f, 6'h39},
    {6'h2a, 6'h15, 6'h0f, 6'h2c, 6'h30, 6'h35, 6'h2d}};
  // Wire level from both parties
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  sync_serial_pin_mux uut (.clk_sys(clk_sys), .rst(rst), .clk_en(ce),
    .stop_req(stop_req), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ser_drv(drv), .ser_in(sin), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  codec_model partner (.frame_on(frame_on), .ctl_lvl(ctl_lvl), .ext(ext));
  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // Write: address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bsp = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
    if (n == 50) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
    if (n == 50) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  // Main sequence
  initial begin
    {rst, stop_req, frame_on, awvalid, wvalid, bready} = 6'h20;
    {arvalid, rready, awaddr, araddr, wdata} = '0;
    ctl_lvl = 2'b00;
    drv = '0;
    ce = 1'b1;
    strb = 4'hf;
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    chk(32'(pin_oe), 32'h0);
    rdr(OFF_FUNC_SEL, rd);
    chk(rd, 32'h0);
    rdr(OFF_DIRECTION, rd);
    chk(rd, 32'h0);
    rdr(8'h20, rd);
    chk(32'(rsp), 32'(RESP_SLVERR));
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      wr(OFF_FUNC_SEL, 32'(rows[i][41:36]));
      wr(OFF_DIRECTION, 32'(rows[i][35:30]));
      wr(OFF_GP_OUT, 32'(rows[i][29:24]));
      chk(32'(bsp), 32'(RESP_OKAY));
      drv <= rows[i][23:12];
      cyc(3);
      chk(32'(pin_oe), 32'(rows[i][11:6]));
      chk(32'(pin_out), 32'(rows[i][5:0]));
    end
    // Synchronous frame from the partner
    wr(OFF_FUNC_SEL, 32'h3f);
    drv <= '0;
    ctl_lvl <= 2'b10;
    cyc(5);
    chk({30'h0, sin.flag1, sin.flag0}, 32'h2);
    frame_on <= 1'b1;
    {ntx, nrx, nfs, nrd, nfl} = '0;
    prev_rd = 1'b0;
    repeat (130) begin
      @(posedge clk_sys);
      ntx += sin.tx_bit_clk_rise;
      nrx += sin.rx_bit_clk_rise;
      nfl += sin.tx_bit_clk_fall;
      nfs += sin.rx_frame_sync && sin.tx_frame_sync;
      nrd += sin.rx_data && !prev_rd;
      prev_rd = sin.rx_data;
    end
    frame_on <= 1'b0;
    chk(ntx, 8);
    chk(nrx, 8);
    chk(nfl, 8);
    chk(nrd, 4);
    chk(32'(nfs > 0), 32'h1);
    // Clock enable low freezes the pin path and the bus
    ce <= 1'b0;
    ctl_lvl <= 2'b01;
    cyc(6);
    chk({30'h0, sin.flag1, sin.flag0}, 32'h2);
    chk({31'h0, awready}, 32'h0);
    ce <= 1'b1;
    cyc(5);
    chk({30'h0, sin.flag1, sin.flag0}, 32'h1);
    // Asynchronous mode: receive clock and sync on control pins
    wr(OFF_MODE, 32'h1);
    ctl_lvl <= 2'b10;
    cyc(5);
    chk({29'h0, sin.rx_frame_sync, sin.flag1, sin.flag0}, 32'h4);
    nrx = 0;
    for (int k = 0; k < 96; k++) begin
      @(posedge clk_sys);
      ctl_lvl[0] <= k[3] && (k < 64);
      nrx += sin.rx_bit_clk_rise;
    end
    chk(nrx, 4);
    // Stop state releases pins and freezes the serial side
    drv <= {6'h00, 6'h20};
    stop_req <= 1'b1;
    cyc(2);
    ctl_lvl <= 2'b01;
    cyc(5);
    chk(32'(pin_oe), 32'h0);
    chk({31'h0, sin.rx_frame_sync}, 32'h1);
    chk({31'h0, sin.rx_bit_clk_rise}, 32'h0);
    rdr(OFF_STATUS, rd);
    chk(rd, 32'h3);
    stop_req <= 1'b0;
    cyc(5);
    chk(32'(pin_oe), 32'h20);
    chk({30'h0, sin.rx_frame_sync, sin.rx_bit_clk}, 32'h1);
    // Reset in mid-run, masked write, unmapped write
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    chk(32'(pin_oe), 32'h0);
    rdr(OFF_MODE, rd);
    chk(rd, 32'h0);
    strb <= 4'h0;
    wr(OFF_FUNC_SEL, 32'h3f);
    chk(32'(bsp), 32'(RESP_OKAY));
    strb <= 4'hf;
    wr(8'h20, 32'h3f);
    chk(32'(bsp), 32'(RESP_SLVERR));
    rdr(OFF_FUNC_SEL, rd);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
